// ---- common/sarseq_consts.svh ----
`ifndef SARSEQ_CONSTS_SVH
`define SARSEQ_CONSTS_SVH
// trial register layout
`define SARSEQ_MSB 4'h9
`define SARSEQ_TRIAL_INIT 10'h200
`define SARSEQ_FULL_CODE 10'h3FF
`define SARSEQ_ZERO 10'h000
// clocks spent waiting for the comparator to pass the two-flop synchroniser
`define SARSEQ_SETTLE 2'h2
// reference ladder: n/1024 of full scale, minus half an lsb (1/2048)
`define SARSEQ_LADDER_DIV 12'h800
`endif

// ---- common/sarseq_pkg.sv ----
package sarseq_pkg;
   typedef enum logic [2:0] {
      SARSEQ_IDLE = 3'b001,
      SARSEQ_CMP = 3'b010,
      SARSEQ_DONE = 3'b100
   } sarseq_state_e;
   typedef logic [9:0] sarseq_code_t;
   // configuration bits from software
   typedef struct packed {
      logic start;
      logic eight_bit;
      logic one_shot;
      logic [1:0] channel_count;
   } sarseq_cfg_s;
   // all state of the sequencer
   typedef struct packed {
      sarseq_state_e state;
      sarseq_code_t trial;
      logic [3:0] bit_idx;
      logic [1:0] chan;
      sarseq_code_t result;
      logic [1:0] result_chan;
      logic result_valid;
      logic irq;
      logic start_d;
      logic [1:0] settle;
   } sarseq_regs_s;
endpackage

// ---- core/sarseq_top.sv ----
// What the document requires
// R01: software changes config only while stopped
// R02: wait 1 us after reference connect
// R03: analog pins set as port inputs
// R04: mode write first, then pin selection
// R05: check interrupt flag before reading result
// R06: repeat modes need undivided cpu clock
// R07: conversion starts with only bit 9 set
// R08: keep bit if reference below input
// R09: set next lower bit before comparing
// R10: bits 7 to 0 likewise, ten compares
// R11: after bit 0, copy trial to result
// R12: result occupies bits 0 through 9
// R13: reference is n/1024 minus half lsb
// R14: 8-bit mode reports upper eight bits
// R15: input above reference gives all ones
// R16: start flag begins on first channel
// R17: one compare per clock, hold when stopped (here one compare every three clocks, two spent settling)
// R18: one-shot completion sets interrupt flag
`include "sarseq_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module sarseq_top
   import sarseq_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic ARST_N,
   input wire sarseq_pkg::sarseq_cfg_s CFG,
   input wire logic COMP_REF_BELOW_IN,
   output logic [9:0] LADDER_CODE,
   output logic [1:0] CHANNEL_SEL,
   output logic BUSY,
   output logic [9:0] RESULT,
   output logic [1:0] RESULT_CHANNEL,
   output logic RESULT_VALID,
   output logic CONV_IRQ
);
   import sarseq_pkg::*;

   sarseq_regs_s s_r;
   sarseq_regs_s s_nxt;
   logic cmp_meta_r;
   logic cmp_sync_r;

   // comparator output is analog-domain; two stages before use
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cmp_meta_r <= 1'b0;
         cmp_sync_r <= 1'b0;
      end else begin
         cmp_meta_r <= COMP_REF_BELOW_IN;
         cmp_sync_r <= cmp_meta_r;
      end
   end

   // result word, upper eight bits in 8-bit mode
   function automatic sarseq_code_t pack_result(input sarseq_code_t t, input logic eight);
      pack_result = eight ? {2'b00, t[9:2]} : t; // see R14, R12
   endfunction

   // sequencer: one decision every three clocks, two of them spent settling
   always_comb begin
      s_nxt = s_r;
      s_nxt.start_d = CFG.start;
      s_nxt.result_valid = 1'b0;
      unique case (s_r.state)
         SARSEQ_IDLE: begin
            // trial held untouched while stopped, see R17
            if (CFG.start && !s_r.start_d) begin
               s_nxt.state = SARSEQ_CMP;
               s_nxt.trial = `SARSEQ_TRIAL_INIT; // see R07
               s_nxt.bit_idx = `SARSEQ_MSB;
               s_nxt.settle = `SARSEQ_SETTLE;
               s_nxt.chan = 2'b00; // see R16
            end
         end
         SARSEQ_CMP: begin
            // deciding before the synchroniser carries this trial's answer would use a stale compare
            if (s_r.settle != 2'h0) begin
               s_nxt.settle = s_r.settle - 2'h1; // see R17
            end else begin
               s_nxt.settle = `SARSEQ_SETTLE;
               // comparator high means ref below input: keep the bit, see R08, R15
               if (!cmp_sync_r) begin
                  s_nxt.trial[s_r.bit_idx] = 1'b0;
               end
               if (s_r.bit_idx != 4'h0) begin
                  s_nxt.trial[s_r.bit_idx - 4'h1] = 1'b1; // see R09
                  s_nxt.bit_idx = s_r.bit_idx - 4'h1; // see R10
               end else begin
                  s_nxt.state = SARSEQ_DONE;
               end
            end
         end
         SARSEQ_DONE: begin
            s_nxt.result = pack_result(s_r.trial, CFG.eight_bit); // see R11
            s_nxt.result_chan = s_r.chan;
            s_nxt.result_valid = 1'b1;
            if (CFG.one_shot && s_r.chan == CFG.channel_count) begin
               s_nxt.irq = 1'b1; // see R18
               s_nxt.state = SARSEQ_IDLE;
            end else if (!CFG.start) begin
               s_nxt.state = SARSEQ_IDLE;
            end else begin
               // next channel, wrapping in repeat modes
               s_nxt.chan = (s_r.chan == CFG.channel_count) ? 2'b00 : s_r.chan + 2'b01;
               s_nxt.trial = `SARSEQ_TRIAL_INIT; // see R07
               s_nxt.bit_idx = `SARSEQ_MSB;
               s_nxt.settle = `SARSEQ_SETTLE;
               s_nxt.state = SARSEQ_CMP;
            end
         end
         default: s_nxt.state = SARSEQ_IDLE;
      endcase
      // a start edge while idle clears the flag; a start edge in DONE is ignored, so a completion set then stays
      if (CFG.start && !s_r.start_d && s_r.state == SARSEQ_IDLE) begin
         s_nxt.irq = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         s_r <= '{state: SARSEQ_IDLE, trial: `SARSEQ_TRIAL_INIT, bit_idx: `SARSEQ_MSB, chan: 2'b00,
                  result: `SARSEQ_ZERO, result_chan: 2'b00, result_valid: 1'b0, irq: 1'b0, start_d: 1'b0,
                  settle: `SARSEQ_SETTLE};
      end else begin
         s_r <= s_nxt;
      end
   end

   // ladder code drives the reference: n/1024 - 1/2048 full scale, see R13
   assign LADDER_CODE = s_r.trial;
   assign CHANNEL_SEL = s_r.chan;
   assign BUSY = (s_r.state != SARSEQ_IDLE);
   assign RESULT = s_r.result;
   assign RESULT_CHANNEL = s_r.result_chan;
   assign RESULT_VALID = s_r.result_valid;
   assign CONV_IRQ = s_r.irq; // see R05
endmodule
`default_nettype wire

// ---- sim/sarseq_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module sarseq_asserts (
   input wire logic CORE_CLK,
   input wire logic ARST_N,
   input wire sarseq_pkg::sarseq_cfg_s CFG,
   input wire logic [9:0] LADDER_CODE,
   input wire logic BUSY,
   input wire logic RESULT_VALID,
   input wire logic CONV_IRQ
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!ARST_N);
   sequence s_take; $rose(CFG.start) && !BUSY; endsequence // start edge while idle
   a_start_take: assert property (s_take |=> BUSY) else $error("start lost");
   a_first_msb: assert property ($rose(BUSY) |-> LADDER_CODE == 10'h200) else $error("bad first trial");
   a_next_bit: assert property ($rose(BUSY) |-> ##3 LADDER_CODE[8:0] == 9'h100) else $error("no bit 8");
   a_lsb_last: assert property ($rose(BUSY) |-> ##27 LADDER_CODE[0]) else $error("no bit 0");
   a_result_lat: assert property ($rose(BUSY) |-> ##31 RESULT_VALID) else $error("late result");
   a_busy_run: assert property ($rose(BUSY) |-> BUSY [*8]) else $error("busy dropped");
   a_hold_idle: assert property (!BUSY && !$past(BUSY) |-> $stable(LADDER_CODE)) else $error("trial moved");
   a_irq_last: assert property (RESULT_VALID && CFG.one_shot && CFG.channel_count == 2'h0 |-> CONV_IRQ)
      else $error("no irq");
endmodule
bind sarseq_top sarseq_asserts chk(.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .CFG(CFG), .LADDER_CODE(LADDER_CODE),
   .BUSY(BUSY), .RESULT_VALID(RESULT_VALID), .CONV_IRQ(CONV_IRQ));
`default_nettype wire

// ---- sim/sarseq_front.sv ----
`timescale 1ns/10ps
`default_nettype none
module sarseq_front (
   input wire logic [9:0] ladder_code,
   input wire logic [11:0] analog_input_voltage,
   output logic below
);
   // levels in half-lsb steps; input held, so no settling modelled; pins are pure inputs
   assign below = ((ladder_code == 10'h000) ? 12'h000 : {1'b0, ladder_code, 1'b0} - 12'h001) < analog_input_voltage;
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk = 1'b0, rst_n = 1'b0, below, busy, vld, irq;
   logic [11:0] analog_input_voltage = 12'h000, v;
   logic [9:0] code, res, expq[$];
   logic [1:0] rch;
   sarseq_pkg::sarseq_cfg_s cfg = '0;
   int n_fail = 0, n_tests = 0, i, w;
   always #4 clk = ~clk; // 125 MHz, undivided
   sarseq_top dut(.CORE_CLK(clk), .ARST_N(rst_n), .CFG(cfg), .COMP_REF_BELOW_IN(below), .LADDER_CODE(code),
      .CHANNEL_SEL(), .BUSY(busy), .RESULT(res), .RESULT_CHANNEL(rch), .RESULT_VALID(vld), .CONV_IRQ(irq));
   sarseq_front fe(.ladder_code(code), .analog_input_voltage(analog_input_voltage), .below(below));
   task chk(input logic [9:0] seen, exp);
      n_tests++;
      if (seen !== exp) n_fail++;
      if (seen !== exp) $display("ERROR %0t: got %h want %h", $time, seen, exp);
   endtask
   task give_verdict;
      $display("checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // each result against the oldest note
   always @(posedge clk) if (vld === 1'b1) begin
      chk(res, expq.pop_front());
      chk({9'h000, irq}, 10'h001);
      chk({8'h00, rch}, 10'h000);
   end
   initial begin
      void'($urandom(94));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 6; i++) begin
         v = (i == 0) ? 12'h000 : (i == 1) ? 12'hFA0 : 12'($urandom) & 12'hFFE;
         expq.push_back(i[0] ? {2'b00, v[11] ? 8'hFF : v[10:3]} : (v[11] ? 10'h3FF : v[10:1]));
         analog_input_voltage <= v;
         cfg <= '{1'b0, i[0], 1'b1, 2'h0}; // config only while stopped
         repeat (3) @(posedge clk); // settle before start
         cfg.start <= 1'b1;
         for (w = 0; w < 60 && vld !== 1'b1; w++) @(posedge clk);
         chk({9'h000, vld}, 10'h001);
         if (w == 60) give_verdict();
         $display("test %0d done", i);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
